//--- posmode_pkg.sv
`default_nettype none
package posmode_pkg;
	typedef enum logic [2:0] {
		MODE_OOS,
		MODE_AUTO,
		MODE_MAN,
		MODE_REMOTE_CASCADE_MODE,
		MODE_LOCAL
	} fb_mode_t;
	typedef enum logic [1:0] {
		REQ_OOS,
		REQ_AUTO,
		REQ_MAN,
		REQ_REMOTE_CASCADE_MODE
	} req_mode_t;
	localparam req_mode_t REQ_MODE_RESET = REQ_AUTO;
	localparam logic [1:0] LIM_OK = 2'h0;
	localparam logic [1:0] LIM_LOW = 2'h1;
	localparam logic [1:0] LIM_HIGH = 2'h2;
	localparam logic [1:0] LIM_CONST = 2'h3;
	localparam logic [1:0] QUAL_BAD = 2'h0;
	localparam logic [1:0] QUAL_UNCERTAIN = 2'h1;
	localparam logic [1:0] QUAL_GOOD_NC = 2'h2;
	localparam logic [1:0] QUAL_GOOD_C = 2'h3;
	localparam logic [3:0] SUB_OK = 4'h0;
	localparam logic [3:0] SUB_C_INIT_ACK = 4'h1;
	localparam logic [3:0] SUB_C_INIT_REQ = 4'h2;
	localparam logic [3:0] SUB_C_NOT_INVITED = 4'h3;
	localparam logic [3:0] SUB_C_LOCAL_OVR = 4'h6;
	localparam logic [3:0] SUB_C_FAILSAFE = 4'h8;
	localparam logic [3:0] SUB_NC_FAILSAFE = 4'h8;
	localparam logic [7:0] STAT_INIT_REQ = 8'hC8;
	localparam logic [7:0] STAT_INIT_ACK = 8'hC4;
	localparam int DIAG_LEN = 14;
	localparam logic [3:0] DIAG_LAST_IDX = 4'hD;
	localparam logic [7:0] DIAG_HDR_LEN = 8'h08;
	localparam logic [7:0] DIAG_STATUS_TYPE = 8'hFE;
	localparam logic [7:0] DIAG_SLOT = 8'h00;
	localparam logic [7:0] SPEC_APPEARED = 8'h01;
	localparam logic [7:0] SPEC_DISAPPEARED = 8'h02;
	localparam logic [7:0] MASTER_ADDR_NONE = 8'hFF;
	localparam int B1_MASTER_LOCK = 7;
	localparam int B1_PRM_FAULT = 6;
	localparam int B1_NOT_SUPP = 4;
	localparam int B1_EXT_DIAG = 3;
	localparam int B1_CFG_FAULT = 2;
	localparam int B1_NOT_READY = 1;
	localparam int B2_WD_ON = 3;
	localparam int B2_ALWAYS1 = 2;
	localparam int B2_STAT_DIAG = 1;
	localparam int B2_PRM_REQ = 0;
	localparam logic [15:0] IDENT_DEVICE_DEFAULT = 16'h1234;
	localparam logic [15:0] IDENT_PROFILE_DEFAULT = 16'h5678;
endpackage
`default_nettype wire

//--- posmode_if.sv
`default_nettype none
interface posmode_if;
	logic [31:0] dev_diag;
	logic [7:0] spec_byte;
	logic diag_any;
	modport src (output dev_diag, input spec_byte, input diag_any);
	modport evt (input dev_diag, output spec_byte, output diag_any);
endinterface
`default_nettype wire

//--- diag_event.sv
`default_nettype none
module diag_event
	import posmode_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// diagnosis bytes
	posmode_if.evt bus
);
	logic [31:0] prev_q;
	logic [7:0] spec_q;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			prev_q <= 32'h0;
		end else begin
			prev_q <= bus.dev_diag;
		end
	end
	// newly set bits win over cleared ones in the same cycle
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			spec_q <= SPEC_DISAPPEARED;
		end else if ((bus.dev_diag & ~prev_q) != 32'h0) begin
			spec_q <= SPEC_APPEARED; // (R13)
		end else if ((prev_q & ~bus.dev_diag) != 32'h0) begin
			spec_q <= SPEC_DISAPPEARED; // (R13)
		end
	end
	assign bus.spec_byte = spec_q;
	assign bus.diag_any = (bus.dev_diag != 32'h0);
endmodule
`default_nettype wire

//--- positioner_mode_and_slave_diag.sv
`default_nettype none
// Operation
// (R1) limit bits: ok, low, high, constant
// (R2) modes: oos, auto, manual, cascade, local
// (R3) requested mode defaults auto; actual readable
// (R4) no autostart keeps oos, output held
// (R5) auto when ready; cascade via auto
// (R6) manual only after autostart; output writable
// (R7) cascade input drives if status allows
// (R8) cascade entry conditions; report init request
// (R9) init acknowledge from master enters cascade
// (R10) local override follows push buttons only
// (R11) diagnosis answer is fourteen bytes
// (R12) header 8, type FE, slot 00
// (R13) specifier appeared 01, disappeared 02
// (R14) ext diag set while diagnosis nonzero
// (R15) master lock bit driven zero
// (R16) prm, unsupported, cfg, not ready flags
// (R17) fixed zero and one bits
// (R18) watchdog active flag in byte 2
// (R19) static diag when no valid data
// (R20) reparameterization request until parameterized
// (R21) master address, 255 until parameterized
// (R22) ident number chosen by select
// (R23) substatus decoded by quality
// (R24) modes evaluated each cycle; bytes ascending
module positioner_mode_and_slave_diag
	import posmode_pkg::*;
#(
	parameter logic [15:0] IDENT_DEVICE = IDENT_DEVICE_DEFAULT, // arbitrary value
	parameter logic [15:0] IDENT_PROFILE = IDENT_PROFILE_DEFAULT // arbitrary value
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// mode control
	input wire logic i_req_mode_we,
	input wire logic [1:0] i_req_mode,
	input wire logic i_autostart_done,
	input wire logic i_config_valid,
	input wire logic i_cyclic_link_ok,
	input wire logic i_local_pb_active,
	input wire logic [7:0] i_setpoint_status,
	input wire logic [7:0] i_cascade_setpoint_status,
	input wire logic [1:0] i_alarm_limit,
	// mode outputs
	output logic [1:0] o_req_mode,
	output logic [2:0] o_actual_mode,
	output logic o_loop_closed,
	output logic o_hold_output,
	output logic o_use_setpoint,
	output logic o_use_cascade,
	output logic o_out_writable,
	output logic [7:0] o_cascade_readback_output,
	output logic [1:0] o_limit_bits,
	// slave status sources
	input wire logic i_prm_fault,
	input wire logic i_not_supported,
	input wire logic i_cfg_fault,
	input wire logic i_not_ready,
	input wire logic i_watchdog_active,
	input wire logic i_user_data_invalid,
	input wire logic i_param_done,
	input wire logic i_param_done_set,
	input wire logic [7:0] i_param_master_addr,
	input wire logic i_ident_select_param,
	input wire logic [31:0] i_device_diag,
	// diagnosis frame
	input wire logic i_diag_req,
	input wire logic i_diag_ready,
	output logic o_diag_valid,
	output logic [7:0] o_diag_byte,
	output logic o_diag_last,
	output logic o_diag_busy
);
	fb_mode_t mode_q, mode_d;
	req_mode_t req_q;
	logic [7:0] master_q;
	logic prm_req_q;
	logic [3:0] idx_q;
	logic busy_q;
	logic [7:0] byte_q;
	logic [3:0] idx_nxt;
	logic [7:0] frame_byte;
	logic [7:0] stat1, stat2, stat3;
	logic [15:0] ident;
	logic casc_ok, sp_ok, ready_op, ack_seen;
	posmode_if dif ();

	assign dif.dev_diag = i_device_diag;
	diag_event u_evt (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.bus(dif.evt)
	);

	// requested mode never holds local override: the encoding has no slot for it
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			req_q <= REQ_MODE_RESET; // (R3)
		end else if (i_req_mode_we) begin
			req_q <= req_mode_t'(i_req_mode); // (R10)
		end
	end

	// status usable: good quality, non-failsafe substatus
	function automatic logic status_ok(input logic [7:0] s);
		logic [1:0] q;
		logic [3:0] sub;
		q = s[7:6];
		sub = s[5:2];
		status_ok = 1'b0;
		case (q) // (R23)
			QUAL_GOOD_NC: status_ok = (sub != SUB_NC_FAILSAFE);
			QUAL_GOOD_C: status_ok = (sub != SUB_C_FAILSAFE);
			QUAL_UNCERTAIN: status_ok = 1'b0;
			default: status_ok = 1'b0;
		endcase
	endfunction

	assign sp_ok = status_ok(i_setpoint_status);
	assign casc_ok = status_ok(i_cascade_setpoint_status);
	assign ready_op = i_autostart_done && i_config_valid;
	assign ack_seen = (i_cascade_setpoint_status == STAT_INIT_ACK);

	always_comb begin
		mode_d = mode_q;
		case (mode_q) // (R24)
			MODE_OOS: begin
				if (!i_autostart_done) begin
					mode_d = MODE_OOS; // (R4)
				end else if (i_local_pb_active) begin
					mode_d = MODE_LOCAL; // (R10)
				end else if (ready_op && (req_q == REQ_AUTO || req_q == REQ_REMOTE_CASCADE_MODE)) begin
					mode_d = MODE_AUTO; // (R5)
				end else if (req_q == REQ_MAN) begin
					mode_d = MODE_MAN; // (R6)
				end
			end
			MODE_AUTO: begin
				if (!i_autostart_done || req_q == REQ_OOS || !i_config_valid) begin
					mode_d = MODE_OOS;
				end else if (i_local_pb_active) begin
					mode_d = MODE_LOCAL;
				end else if (req_q == REQ_MAN) begin
					mode_d = MODE_MAN;
				end else if (req_q == REQ_REMOTE_CASCADE_MODE && i_cyclic_link_ok && ack_seen) begin
					mode_d = MODE_REMOTE_CASCADE_MODE; // (R9)
				end
			end
			MODE_MAN: begin
				if (!i_autostart_done || req_q == REQ_OOS) begin
					mode_d = MODE_OOS;
				end else if (i_local_pb_active) begin
					mode_d = MODE_LOCAL;
				end else if (ready_op && (req_q == REQ_AUTO || req_q == REQ_REMOTE_CASCADE_MODE)) begin
					mode_d = MODE_AUTO; // (R5)
				end
			end
			MODE_REMOTE_CASCADE_MODE: begin
				if (!i_autostart_done || req_q == REQ_OOS) begin
					mode_d = MODE_OOS;
				end else if (i_local_pb_active) begin
					mode_d = MODE_LOCAL;
				end else if (req_q == REQ_MAN) begin
					mode_d = MODE_MAN;
				end else if (req_q == REQ_AUTO || !i_cyclic_link_ok || !i_config_valid) begin
					mode_d = MODE_AUTO;
				end
			end
			MODE_LOCAL: begin
				// leaving local always goes through oos; next cycle re-picks target
				if (!i_local_pb_active) begin
					mode_d = MODE_OOS; // (R10)
				end
			end
			default: mode_d = MODE_OOS;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_q <= MODE_OOS; // (R2)
		end else begin
			mode_q <= mode_d;
		end
	end

	assign o_req_mode = req_q;
	assign o_actual_mode = mode_q; // (R3)
	assign o_hold_output = (mode_q == MODE_OOS) || (mode_q == MODE_LOCAL); // (R4)
	assign o_loop_closed = (mode_q == MODE_AUTO) || (mode_q == MODE_MAN) || (mode_q == MODE_REMOTE_CASCADE_MODE);
	assign o_use_setpoint = (mode_q == MODE_AUTO) && sp_ok; // (R5)
	assign o_use_cascade = (mode_q == MODE_REMOTE_CASCADE_MODE) && casc_ok; // (R7)
	assign o_out_writable = (mode_q == MODE_MAN); // (R6)

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cascade_readback_output <= {QUAL_GOOD_C, SUB_C_NOT_INVITED, LIM_CONST};
		end else if (mode_q == MODE_LOCAL) begin
			o_cascade_readback_output <= {QUAL_GOOD_C, SUB_C_LOCAL_OVR, LIM_CONST};
		end else if (mode_q == MODE_AUTO && req_q == REQ_REMOTE_CASCADE_MODE && i_autostart_done
				&& i_cyclic_link_ok) begin
			o_cascade_readback_output <= STAT_INIT_REQ; // (R8)
		end else if (mode_q == MODE_REMOTE_CASCADE_MODE) begin
			o_cascade_readback_output <= {QUAL_GOOD_C, SUB_OK, i_alarm_limit};
		end else begin
			o_cascade_readback_output <= {QUAL_GOOD_C, SUB_C_NOT_INVITED, o_limit_bits};
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_limit_bits <= LIM_CONST;
		end else if (mode_d == MODE_OOS || mode_d == MODE_MAN || mode_d == MODE_LOCAL) begin
			o_limit_bits <= LIM_CONST; // (R1)
		end else if (i_alarm_limit == LIM_LOW || i_alarm_limit == LIM_HIGH) begin
			o_limit_bits <= i_alarm_limit; // (R1)
		end else begin
			o_limit_bits <= LIM_OK;
		end
	end

	// owning master address; loaded on every i_param_done_set, kept until the next load or reset
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			master_q <= MASTER_ADDR_NONE;
		end else if (i_param_done_set) begin
			master_q <= i_param_master_addr; // (R21)
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			prm_req_q <= 1'b1;
		end else if (i_param_done) begin
			prm_req_q <= 1'b0; // (R20)
		end
	end

	always_comb begin
		stat1 = 8'h00;
		stat1[B1_MASTER_LOCK] = 1'b0; // (R15)
		stat1[B1_PRM_FAULT] = i_prm_fault; // (R16)
		stat1[B1_NOT_SUPP] = i_not_supported; // (R16)
		stat1[B1_EXT_DIAG] = dif.diag_any; // (R14)
		stat1[B1_CFG_FAULT] = i_cfg_fault; // (R16)
		stat1[B1_NOT_READY] = i_not_ready; // (R16)
		stat2 = 8'h00; // (R17)
		stat2[B2_WD_ON] = i_watchdog_active; // (R18)
		stat2[B2_ALWAYS1] = 1'b1; // (R17)
		stat2[B2_STAT_DIAG] = i_user_data_invalid; // (R19)
		stat2[B2_PRM_REQ] = prm_req_q; // (R20)
		stat3 = 8'h00; // (R17)
	end

	assign ident = i_ident_select_param ? IDENT_PROFILE : IDENT_DEVICE; // (R22)

	// index of the byte that the next edge loads
	always_comb begin
		if (!busy_q) begin
			idx_nxt = 4'h0;
		end else if (i_diag_ready && idx_q != DIAG_LAST_IDX) begin
			idx_nxt = idx_q + 4'h1;
		end else begin
			idx_nxt = idx_q;
		end
	end

	always_comb begin
		case (idx_nxt) // (R11)
			4'h0: frame_byte = stat1;
			4'h1: frame_byte = stat2;
			4'h2: frame_byte = stat3;
			4'h3: frame_byte = master_q;
			4'h4: frame_byte = ident[15:8];
			4'h5: frame_byte = ident[7:0];
			4'h6: frame_byte = DIAG_HDR_LEN; // (R12)
			4'h7: frame_byte = DIAG_STATUS_TYPE; // (R12)
			4'h8: frame_byte = DIAG_SLOT; // (R12)
			4'h9: frame_byte = dif.spec_byte;
			4'hA: frame_byte = i_device_diag[7:0];
			4'hB: frame_byte = i_device_diag[15:8];
			4'hC: frame_byte = i_device_diag[23:16];
			4'hD: frame_byte = i_device_diag[31:24];
			default: frame_byte = 8'h00;
		endcase
	end

	// each byte is sampled as it is loaded, then stands still while the sink stalls
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			busy_q <= 1'b0;
			idx_q <= 4'h0;
			byte_q <= 8'h00;
		end else if (!busy_q) begin
			if (i_diag_req) begin
				busy_q <= 1'b1;
				idx_q <= 4'h0;
				byte_q <= frame_byte;
			end
		end else if (i_diag_ready) begin
			if (idx_q == DIAG_LAST_IDX) begin
				busy_q <= 1'b0;
				idx_q <= 4'h0;
				byte_q <= 8'h00;
			end else begin
				idx_q <= idx_q + 4'h1; // (R24)
				byte_q <= frame_byte;
			end
		end
	end

	assign o_diag_valid = busy_q;
	assign o_diag_byte = byte_q;
	assign o_diag_last = busy_q && (idx_q == DIAG_LAST_IDX);
	assign o_diag_busy = busy_q;
endmodule
`default_nettype wire

//--- posmode_props.sv
`default_nettype none
module posmode_props
	import posmode_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// watched inputs
	input wire logic i_autostart_done,
	input wire logic i_cyclic_link_ok,
	input wire logic i_local_pb_active,
	input wire logic [7:0] i_cascade_setpoint_status,
	input wire logic i_watchdog_active,
	input wire logic [31:0] i_device_diag,
	input wire logic i_diag_req,
	input wire logic i_diag_ready,
	// watched outputs
	input wire logic [1:0] o_req_mode,
	input wire logic [2:0] o_actual_mode,
	input wire logic o_hold_output,
	input wire logic [7:0] o_cascade_readback_output,
	input wire logic [1:0] o_limit_bits,
	input wire logic o_diag_valid,
	input wire logic [7:0] o_diag_byte,
	input wire logic o_diag_last,
	input wire logic o_diag_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	// byte position within the frame being sent
	logic [3:0] cnt_q;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= 4'h0;
		end else if (o_diag_valid && i_diag_ready) begin
			cnt_q <= o_diag_last ? 4'h0 : cnt_q + 4'h1;
		end
	end
	limit_const_a: assert property (o_actual_mode inside {MODE_OOS, MODE_MAN, MODE_LOCAL}
		|-> o_limit_bits == LIM_CONST) else $error("limit bits not constant");
	oos_stay_a: assert property (!i_autostart_done && !i_local_pb_active
		|=> o_actual_mode == MODE_OOS) else $error("left oos without autostart");
	oos_hold_a: assert property (o_actual_mode == MODE_OOS |-> o_hold_output)
		else $error("output not held in oos");
	init_req_a: assert property ((o_actual_mode == MODE_AUTO && o_req_mode == REQ_REMOTE_CASCADE_MODE
		&& i_autostart_done && i_cyclic_link_ok)[*2]
		|-> o_cascade_readback_output == STAT_INIT_REQ) else $error("no init request");
	remote_cascade_mode_entry_a: assert property (o_actual_mode == MODE_REMOTE_CASCADE_MODE
		&& $past(o_actual_mode) != MODE_REMOTE_CASCADE_MODE |-> $past(o_actual_mode) == MODE_AUTO
		&& $past(i_cascade_setpoint_status) == STAT_INIT_ACK) else $error("bad cascade entry");
	local_pb_a: assert property (o_actual_mode == MODE_LOCAL |-> $past(i_local_pb_active))
		else $error("local mode without push buttons");
	diag_start_a: assert property (i_diag_req && !o_diag_busy |=> o_diag_valid)
		else $error("diagnosis request not answered");
	frame_len_a: assert property (o_diag_valid |-> o_diag_last == (cnt_q == DIAG_LAST_IDX))
		else $error("frame length wrong");
	hdr_bytes_a: assert property (o_diag_valid && cnt_q inside {4'h6, 4'h7, 4'h8}
		|-> o_diag_byte == (cnt_q == 4'h6 ? DIAG_HDR_LEN : cnt_q == 4'h7 ? DIAG_STATUS_TYPE
		: DIAG_SLOT)) else $error("header bytes wrong");
	first_byte_a: assert property (o_diag_valid && cnt_q == 4'h0 |-> !o_diag_byte[7]
		&& !o_diag_byte[5] && !o_diag_byte[0] && o_diag_byte[3] == |i_device_diag)
		else $error("first status byte wrong");
	second_byte_a: assert property (o_diag_valid && cnt_q == 4'h1 |-> o_diag_byte[2]
		&& o_diag_byte[3] == i_watchdog_active && o_diag_byte[7:4] == 4'h0)
		else $error("second status byte wrong");
	cover property (o_actual_mode == MODE_REMOTE_CASCADE_MODE);
	cover property (o_actual_mode == MODE_LOCAL);
	cover property (o_diag_valid && o_diag_last && i_diag_ready);
endmodule
bind positioner_mode_and_slave_diag posmode_props props (.i_clock, .i_rstn, .i_autostart_done,
	.i_cyclic_link_ok, .i_local_pb_active, .i_cascade_setpoint_status, .i_watchdog_active,
	.i_device_diag, .i_diag_req, .i_diag_ready, .o_req_mode, .o_actual_mode, .o_hold_output,
	.o_cascade_readback_output, .o_limit_bits, .o_diag_valid, .o_diag_byte, .o_diag_last,
	.o_diag_busy);
`default_nettype wire

//--- fieldbus_master_model.sv
`default_nettype none
module fieldbus_master_model
	import posmode_pkg::*;
#(
	parameter logic [7:0] OWN_ADDR = 8'h01
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rstn,
	// behaviour
	input wire logic i_ack_en,
	input wire logic i_slow,
	// cyclic data
	input wire logic [7:0] i_readback,
	output logic [7:0] o_cas_status,
	// diagnosis fetch
	input wire logic i_valid,
	input wire logic [7:0] i_byte,
	input wire logic i_last,
	output logic o_ready,
	output logic o_done,
	output logic o_lock
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] frame [0:13];
	logic [3:0] idx_q;
	logic phase_q;
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_cas_status <= 8'hC0;
		end else begin
			// a silent master lets the bench hold the block in auto
			o_cas_status <= (i_ack_en && i_readback == STAT_INIT_REQ) ? STAT_INIT_ACK : 8'hC0;
		end
	end
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			idx_q <= 4'h0;
			phase_q <= 1'b0;
			o_done <= 1'b0;
		end else begin
			phase_q <= ~phase_q;
			o_done <= i_valid && o_ready && i_last;
			if (i_valid && o_ready) begin
				frame[idx_q] <= i_byte;
				idx_q <= i_last ? 4'h0 : idx_q + 4'h1;
			end
		end
	end
	// slow mode stalls every other cycle
	assign o_ready = i_valid && (!i_slow || phase_q);
	// lock judged by the master itself from the owner byte
	assign o_lock = frame[3] != MASTER_ADDR_NONE && frame[3] != OWN_ADDR;
endmodule
`default_nettype wire

//--- test_positioner_mode_and_slave_diag.sv
`default_nettype none
module test_positioner_mode_and_slave_diag;
	timeunit 1ns;
	timeprecision 100ps;
	import posmode_pkg::*;
	logic i_clock, i_rstn, i_req_mode_we, i_autostart_done, i_config_valid, i_cyclic_link_ok;
	logic i_local_pb_active, i_prm_fault, i_not_supported, i_cfg_fault, i_not_ready;
	logic i_watchdog_active, i_user_data_invalid, i_param_done, i_param_done_set;
	logic i_ident_select_param, i_diag_req, i_diag_ready, ack_en, slow, m_done, m_lock;
	logic [1:0] i_req_mode, i_alarm_limit, o_req_mode, o_limit_bits;
	logic [7:0] i_setpoint_status, i_cascade_setpoint_status, i_param_master_addr;
	logic [31:0] i_device_diag;
	logic [2:0] o_actual_mode;
	logic o_loop_closed, o_hold_output, o_use_setpoint, o_use_cascade, o_out_writable;
	logic o_diag_valid, o_diag_last, o_diag_busy;
	logic [7:0] o_cascade_readback_output, o_diag_byte, e_spec, e_addr;
	logic e_prm;
	int fails, total_checks, cycles, k;
	positioner_mode_and_slave_diag dut (.i_clock, .i_rstn, .i_req_mode_we, .i_req_mode,
		.i_autostart_done, .i_config_valid, .i_cyclic_link_ok, .i_local_pb_active,
		.i_setpoint_status, .i_cascade_setpoint_status, .i_alarm_limit, .o_req_mode,
		.o_actual_mode, .o_loop_closed, .o_hold_output, .o_use_setpoint, .o_use_cascade,
		.o_out_writable, .o_cascade_readback_output, .o_limit_bits, .i_prm_fault,
		.i_not_supported, .i_cfg_fault, .i_not_ready, .i_watchdog_active, .i_user_data_invalid,
		.i_param_done, .i_param_done_set, .i_param_master_addr, .i_ident_select_param,
		.i_device_diag, .i_diag_req, .i_diag_ready, .o_diag_valid, .o_diag_byte, .o_diag_last,
		.o_diag_busy);
	fieldbus_master_model master (.i_clock, .i_rstn, .i_ack_en(ack_en), .i_slow(slow),
		.i_readback(o_cascade_readback_output), .o_cas_status(i_cascade_setpoint_status),
		.i_valid(o_diag_valid), .i_byte(o_diag_byte), .i_last(o_diag_last),
		.o_ready(i_diag_ready), .o_done(m_done), .o_lock(m_lock));
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// hang guard, far above the hundred-odd cycles needed
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			print_verdict();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic set_req(input logic [1:0] m);
		i_req_mode = m;
		i_req_mode_we = 1'b1;
		tick(1);
		i_req_mode_we = 1'b0;
	endtask
	task automatic wait_mode(input logic [2:0] m);
		for (int n = 0; n < 10 && o_actual_mode !== m; n++) tick(1);
		check("actual mode", o_actual_mode, m);
	endtask
	function automatic logic [7:0] exp_byte(input int i);
		logic [15:0] id;
		id = i_ident_select_param ? IDENT_PROFILE_DEFAULT : IDENT_DEVICE_DEFAULT;
		case (i)
			0: return {1'b0, i_prm_fault, 1'b0, i_not_supported, |i_device_diag, i_cfg_fault,
				i_not_ready, 1'b0};
			1: return {4'h0, i_watchdog_active, 1'b1, i_user_data_invalid, e_prm};
			2: return 8'h00;
			3: return e_addr;
			4: return id[15:8];
			5: return id[7:0];
			6: return DIAG_HDR_LEN;
			7: return DIAG_STATUS_TYPE;
			8: return DIAG_SLOT;
			9: return e_spec;
			default: return i_device_diag[8 * (i - 10) +: 8];
		endcase
	endfunction
	initial begin
		void'($urandom(58));
		{i_rstn, i_req_mode_we, i_req_mode, i_autostart_done, i_config_valid} = '0;
		{i_cyclic_link_ok, i_local_pb_active, i_alarm_limit, i_diag_req, slow} = '0;
		{i_prm_fault, i_not_supported, i_cfg_fault, i_not_ready, i_watchdog_active} = '0;
		{i_user_data_invalid, i_param_done, i_param_done_set, i_ident_select_param} = '0;
		i_param_master_addr = 8'h00;
		i_device_diag = 32'h0;
		i_setpoint_status = 8'h80;
		ack_en = 1'b0;
		tick(10);
		i_rstn = 1'b1;
		tick(1);
		check("req mode", o_req_mode, REQ_AUTO);
		check("limits", o_limit_bits, LIM_CONST);
		i_config_valid = 1'b1;
		set_req(REQ_MAN);
		tick(3);
		check("oos held", {o_actual_mode, o_hold_output}, {MODE_OOS, 1'b1});
		i_autostart_done = 1'b1;
		set_req(REQ_AUTO);
		wait_mode(MODE_AUTO);
		check("auto loop", {o_loop_closed, o_use_setpoint}, 2'h3);
		i_setpoint_status = 8'($urandom_range(63));
		tick(1);
		check("sp bad", o_use_setpoint, 1'b0);
		i_setpoint_status = 8'hA0;
		tick(1);
		check("sp failsafe", o_use_setpoint, 1'b0);
		i_setpoint_status = 8'h80;
		for (k = 0; k < 4; k++) begin
			i_alarm_limit = 2'(k);
			tick(2);
			check("limits", o_limit_bits, k == 1 ? LIM_LOW : k == 2 ? LIM_HIGH : LIM_OK);
		end
		set_req(REQ_MAN);
		wait_mode(MODE_MAN);
		check("man", {o_limit_bits, o_out_writable, o_use_setpoint}, {LIM_CONST, 2'h2});
		i_cyclic_link_ok = 1'b1;
		set_req(REQ_REMOTE_CASCADE_MODE);
		wait_mode(MODE_AUTO);
		tick(4);
		check("init mode", o_actual_mode, MODE_AUTO);
		check("init req", o_cascade_readback_output, STAT_INIT_REQ);
		ack_en = 1'b1;
		wait_mode(MODE_REMOTE_CASCADE_MODE);
		check("cascade", {o_use_cascade, o_loop_closed}, 2'h3);
		i_local_pb_active = 1'b1;
		wait_mode(MODE_LOCAL);
		set_req(REQ_AUTO);
		tick(3);
		check("local", {o_actual_mode, o_limit_bits}, {MODE_LOCAL, LIM_CONST});
		i_local_pb_active = 1'b0;
		wait_mode(MODE_AUTO);
		for (k = 0; k < 3; k++) begin
			if (k == 1) begin
				i_param_master_addr = 8'($urandom_range(125));
				{i_param_done, i_param_done_set} = 2'h3;
				tick(1);
				{i_param_done, i_param_done_set} = 2'h0;
			end
			{i_prm_fault, i_not_supported, i_cfg_fault, i_not_ready} = k ? 4'($urandom) : 4'h0;
			{i_watchdog_active, i_user_data_invalid} = k ? 2'($urandom) : 2'h0;
			i_device_diag = (k == 1) ? ($urandom | 32'h1) : 32'h0;
			i_ident_select_param = (k == 1);
			slow = (k == 1);
			e_spec = (k == 1) ? SPEC_APPEARED : SPEC_DISAPPEARED;
			e_addr = k ? i_param_master_addr : MASTER_ADDR_NONE;
			e_prm = (k == 0);
			tick(3);
			i_diag_req = 1'b1;
			tick(k + 1);
			i_diag_req = 1'b0;
			for (int n = 0; n < 60 && m_done !== 1'b1; n++) tick(1);
			check("frame end", {m_done, o_diag_busy}, 2'h2);
			check("lock", m_lock, e_addr != MASTER_ADDR_NONE && e_addr != 8'h01);
			for (int i = 0; i < DIAG_LEN; i++) begin
				check("diag byte", master.frame[i], exp_byte(i));
			end
		end
		print_verdict();
	end
endmodule
`default_nettype wire
